// ---- rtl/pcic_top.v ----
// Summary of operation
// [R01] receive-global bit set: code write fills every receive channel entry.
// [R02] transmit-global bit set: code write fills every transmit channel entry.
// [R03] global bits pick scope: one channel, all tx, all rx, or all.
// [R04] software keeps both global bits zero while reading through the pointer.
// [R05] software writes pointer 01h..20h for E1, 01h..18h for T1.
// [R06] six-bit pointer field selects the channel entry; channel 1 is 01h.
// [R07] the code register value is written into the addressed entry.
// [R08] inserted code goes out bit 7 first, bit 0 last.
// [R09] tx channel with enable set carries its code, else data unchanged.
// [R10] tx enable regs 80h/81h: bits 7..0 map channels 8..1 and 16..9.
// [R11] tx enable regs 82h/83h: channels 24..17 and 32..25.
// [R12] rx enable regs 84h..87h substitute codes into receive channels 1..32.
// [R13] entry update happens on the code register write, using current pointer.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "pcic_map.vh"

// ==========================================================
// per-bit timeslot substitution stage
module pcic_slot_insert #(
  parameter NCH = 32
) (
  input  wire           core_clk_i,
  input  wire           rst_i,
  input  wire           valid_i,
  input  wire [5:0]     chan_i,
  input  wire [2:0]     bit_idx_i,
  input  wire           bit_i,
  input  wire [NCH-1:0] en_vec_i,
  input  wire [7:0]     code_i,
  output reg            valid_o,
  output reg  [5:0]     chan_o,
  output reg  [2:0]     bit_idx_o,
  output reg            bit_o,
  output reg            fill_o
);
  wire       chan_ok;
  wire [5:0] chan_idx;
  wire       fill_now;

  assign chan_ok  = (chan_i >= `PCIC_CH_FIRST) && (chan_i <= NCH);
  assign chan_idx = chan_i - 6'h01;
  assign fill_now = valid_i && chan_ok && en_vec_i[chan_idx[4:0]]; // [R09] [R12]

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      valid_o   <= 1'b0;
      chan_o    <= 6'h00;
      bit_idx_o <= 3'h0;
      bit_o     <= 1'b0;
      fill_o    <= 1'b0;
    end else begin
      valid_o   <= valid_i;
      chan_o    <= chan_i;
      bit_idx_o <= bit_idx_i;
      fill_o    <= fill_now;
      if (fill_now) begin
        // index 0 is first on the line, so it takes code bit 7
        bit_o <= code_i[3'h7 - bit_idx_i]; // [R08]
      end else begin
        bit_o <= bit_i; // [R09]
      end
    end
  end
endmodule

// ==========================================================
// idle-code array, registers and both stream paths
module pcic_top #(
  parameter NCH = 32
) (
  input  wire       core_clk_i,
  input  wire       rst_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  output reg  [7:0] reg_rdata_o,
  input  wire       tx_valid_i,
  input  wire [5:0] tx_chan_i,
  input  wire [2:0] tx_bit_idx_i,
  input  wire       tx_bit_i,
  output wire       tx_valid_o,
  output wire [5:0] tx_chan_o,
  output wire [2:0] tx_bit_idx_o,
  output wire       tx_bit_o,
  output wire       tx_fill_o,
  input  wire       rx_valid_i,
  input  wire [5:0] rx_chan_i,
  input  wire [2:0] rx_bit_idx_i,
  input  wire       rx_bit_i,
  output wire       rx_valid_o,
  output wire [5:0] rx_chan_o,
  output wire [2:0] rx_bit_idx_o,
  output wire       rx_bit_o,
  output wire       rx_fill_o
);
  // ========================================================
  // storage
  reg  [7:0]     ptr_q;
  reg  [7:0]     code_q;
  reg  [7:0]     dir_q;
  reg  [NCH-1:0] tx_en_q;
  reg  [NCH-1:0] rx_en_q;
  reg  [7:0]     tx_mem [0:NCH-1];
  reg  [7:0]     rx_mem [0:NCH-1];
  reg  [7:0]     rdata_d;
  integer        i;
  integer        j;

  // ========================================================
  // decode
  wire       wr_ptr;
  wire       wr_code;
  wire       wr_dir;
  wire       rd_entry;
  wire [7:0] entry_val;
  wire       glob_rx;
  wire       glob_tx;
  wire [5:0] ptr_chan;
  wire [5:0] ptr_idx6;
  wire [4:0] ptr_idx;
  wire       ptr_ok;
  wire       single;
  wire [5:0] tx_idx6;
  wire [5:0] rx_idx6;
  wire [7:0] tx_code;
  wire [7:0] rx_code;

  assign wr_ptr   = reg_wr_i && (reg_addr_i == `PCIC_PTR_OFF);
  assign wr_code  = reg_wr_i && (reg_addr_i == `PCIC_CODE_OFF); // [R13]
  assign wr_dir   = reg_wr_i && (reg_addr_i == `PCIC_DIR_OFF);
  assign glob_rx  = ptr_q[`PCIC_GRX_BIT];
  assign glob_tx  = ptr_q[`PCIC_GTX_BIT];
  assign ptr_chan = ptr_q[`PCIC_PTR_MSB:`PCIC_PTR_LSB]; // [R06]
  assign ptr_ok   = (ptr_chan >= `PCIC_CH_FIRST) && (ptr_chan <= NCH); // [R05]
  assign ptr_idx6 = ptr_chan - 6'h01; // [R06]
  assign ptr_idx  = ptr_idx6[4:0];
  assign single   = !glob_rx && !glob_tx; // [R03]
  assign rd_entry = ptr_ok && single; // [R04]
  assign entry_val = dir_q[0] ? rx_mem[ptr_idx] : tx_mem[ptr_idx];
  assign tx_idx6  = tx_chan_i - 6'h01;
  assign rx_idx6  = rx_chan_i - 6'h01;
  assign tx_code  = tx_mem[tx_idx6[4:0]];
  assign rx_code  = rx_mem[rx_idx6[4:0]];

  // ========================================================
  // pointer register
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      ptr_q <= `PCIC_REG_RST;
    end else if (wr_ptr) begin
      ptr_q <= reg_wdata_i; // [R06]
    end
  end

  // ========================================================
  // code register
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      code_q <= `PCIC_REG_RST;
    end else if (wr_code) begin
      code_q <= reg_wdata_i; // [R07]
    end
  end

  // ========================================================
  // single-channel update direction
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      dir_q <= `PCIC_REG_RST;
    end else if (wr_dir) begin
      dir_q <= {7'h00, reg_wdata_i[0]};
    end
  end

  // ========================================================
  // channel enable registers
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_en_q <= {NCH{1'b0}};
      rx_en_q <= {NCH{1'b0}};
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `PCIC_TXEN0_OFF: tx_en_q[7:0] <= reg_wdata_i; // [R10]
        `PCIC_TXEN1_OFF: tx_en_q[15:8] <= reg_wdata_i; // [R10]
        `PCIC_TXEN2_OFF: tx_en_q[23:16] <= reg_wdata_i; // [R11]
        `PCIC_TXEN3_OFF: tx_en_q[31:24] <= reg_wdata_i; // [R11]
        `PCIC_RXEN0_OFF: rx_en_q[7:0] <= reg_wdata_i; // [R12]
        `PCIC_RXEN1_OFF: rx_en_q[15:8] <= reg_wdata_i; // [R12]
        `PCIC_RXEN2_OFF: rx_en_q[23:16] <= reg_wdata_i; // [R12]
        `PCIC_RXEN3_OFF: rx_en_q[31:24] <= reg_wdata_i; // [R12]
        default: tx_en_q <= tx_en_q;
      endcase
    end
  end

  // ========================================================
  // transmit idle-code array update on code write
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      for (i = 0; i < NCH; i = i + 1) begin
        tx_mem[i] <= `PCIC_REG_RST;
      end
    end else if (wr_code) begin
      for (i = 0; i < NCH; i = i + 1) begin
        if (glob_tx) begin
          tx_mem[i] <= reg_wdata_i; // [R02] [R03]
        end
      end
      if (single && ptr_ok && !dir_q[0]) begin
        tx_mem[ptr_idx] <= reg_wdata_i; // [R07] [R03]
      end
    end
  end

  // ========================================================
  // receive idle-code array update on code write
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      for (j = 0; j < NCH; j = j + 1) begin
        rx_mem[j] <= `PCIC_REG_RST;
      end
    end else if (wr_code) begin
      for (j = 0; j < NCH; j = j + 1) begin
        if (glob_rx) begin
          rx_mem[j] <= reg_wdata_i; // [R01] [R03]
        end
      end
      if (single && ptr_ok && dir_q[0]) begin
        rx_mem[ptr_idx] <= reg_wdata_i; // [R07] [R03]
      end
    end
  end

  // ========================================================
  // read path, data one cycle after the strobe
  always @* begin
    rdata_d = `PCIC_RD_UNMAPPED;
    case (reg_addr_i)
      `PCIC_PTR_OFF:   rdata_d = ptr_q;
      `PCIC_CODE_OFF: begin
        // entry read back through the pointer, global bits held at zero
        if (rd_entry) begin // [R04]
          rdata_d = entry_val;
        end else begin
          rdata_d = code_q;
        end
      end
      `PCIC_DIR_OFF:   rdata_d = dir_q;
      `PCIC_TXEN0_OFF: rdata_d = tx_en_q[7:0];
      `PCIC_TXEN1_OFF: rdata_d = tx_en_q[15:8];
      `PCIC_TXEN2_OFF: rdata_d = tx_en_q[23:16];
      `PCIC_TXEN3_OFF: rdata_d = tx_en_q[31:24];
      `PCIC_RXEN0_OFF: rdata_d = rx_en_q[7:0];
      `PCIC_RXEN1_OFF: rdata_d = rx_en_q[15:8];
      `PCIC_RXEN2_OFF: rdata_d = rx_en_q[23:16];
      `PCIC_RXEN3_OFF: rdata_d = rx_en_q[31:24];
      default:         rdata_d = `PCIC_RD_UNMAPPED;
    endcase
  end

  // ========================================================
  // read data register, cleared outside the answer cycle
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= `PCIC_REG_RST;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_d;
    end else begin
      reg_rdata_o <= `PCIC_REG_RST;
    end
  end

  // ========================================================
  // transmit and receive substitution
  pcic_slot_insert #(.NCH(NCH)) u_tx (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .valid_i    (tx_valid_i),
    .chan_i     (tx_chan_i),
    .bit_idx_i  (tx_bit_idx_i),
    .bit_i      (tx_bit_i),
    .en_vec_i   (tx_en_q),
    .code_i     (tx_code),
    .valid_o    (tx_valid_o),
    .chan_o     (tx_chan_o),
    .bit_idx_o  (tx_bit_idx_o),
    .bit_o      (tx_bit_o),
    .fill_o     (tx_fill_o)
  );

  pcic_slot_insert #(.NCH(NCH)) u_rx (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .valid_i    (rx_valid_i),
    .chan_i     (rx_chan_i),
    .bit_idx_i  (rx_bit_idx_i),
    .bit_i      (rx_bit_i),
    .en_vec_i   (rx_en_q),
    .code_i     (rx_code),
    .valid_o    (rx_valid_o),
    .chan_o     (rx_chan_o),
    .bit_idx_o  (rx_bit_idx_o),
    .bit_o      (rx_bit_o),
    .fill_o     (rx_fill_o)
  );
endmodule

// ---- pkg/pcic_map.vh ----
`ifndef PCIC_MAP_VH
`define PCIC_MAP_VH

// ==========================================================
// register offsets (byte addresses on the register port)
`define PCIC_PTR_OFF      8'h7E
`define PCIC_CODE_OFF     8'h7F
`define PCIC_TXEN0_OFF    8'h80
`define PCIC_TXEN1_OFF    8'h81
`define PCIC_TXEN2_OFF    8'h82
`define PCIC_TXEN3_OFF    8'h83
`define PCIC_RXEN0_OFF    8'h84
`define PCIC_RXEN1_OFF    8'h85
`define PCIC_RXEN2_OFF    8'h86
`define PCIC_RXEN3_OFF    8'h87
`define PCIC_DIR_OFF      8'h90

// ==========================================================
// pointer register fields
`define PCIC_GRX_BIT      7
`define PCIC_GTX_BIT      6
`define PCIC_PTR_MSB      5
`define PCIC_PTR_LSB      0

// ==========================================================
// reset values and limits
`define PCIC_REG_RST      8'h00
`define PCIC_RD_UNMAPPED  8'h00
`define PCIC_CH_FIRST     6'h01
`define PCIC_CH_LAST      6'h20
`define PCIC_CH_LAST_T1   6'h18

`endif

// ---- tb/pcic_checker.sv ----
`timescale 1ns/1ps
// ==========================================================
// register and stream checks
module pcic_checker #(
  parameter NCH = 32
) (
  input wire       core_clk_i,
  input wire       rst_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_wr_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire       tx_valid_i,
  input wire [5:0] tx_chan_i,
  input wire [2:0] tx_bit_idx_i,
  input wire [2:0] tx_bit_idx_o,
  input wire [2:0] rx_bit_idx_i,
  input wire [2:0] rx_bit_idx_o,
  input wire       tx_bit_i,
  input wire       tx_valid_o,
  input wire [5:0] tx_chan_o,
  input wire       tx_bit_o,
  input wire       tx_fill_o,
  input wire       rx_valid_i,
  input wire [5:0] rx_chan_i,
  input wire       rx_bit_i,
  input wire       rx_valid_o,
  input wire [5:0] rx_chan_o,
  input wire       rx_bit_o,
  input wire       rx_fill_o
);
  reg  [32:0] ten_q;
  reg  [32:0] ren_q;
  wire        tx_sel = (tx_chan_i <= NCH) && ten_q[tx_chan_i];
  wire        rx_sel = (rx_chan_i <= NCH) && ren_q[rx_chan_i];
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // shadow of the enable registers, bit n is channel n
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      ten_q <= 33'h0;
      ren_q <= 33'h0;
    end else if (reg_wr_i && reg_addr_i[7:3] == 5'h10) begin
      if (reg_addr_i[2]) ren_q[reg_addr_i[1:0]*8+1 +: 8] <= reg_wdata_i;
      else ten_q[reg_addr_i[1:0]*8+1 +: 8] <= reg_wdata_i;
    end
  end
  sequence s_ptr_one;
    reg_wr_i && reg_addr_i == 8'h7E && reg_wdata_i[7:6] == 2'b00
      && reg_wdata_i[5:0] != 6'h00 && reg_wdata_i[5:0] <= NCH;
  endsequence
  sequence s_code_wr;
    reg_wr_i && reg_addr_i == 8'h7F;
  endsequence
  sequence s_code_rd;
    reg_rd_i && reg_addr_i == 8'h7F;
  endsequence
  chk_tx_fill_en: assert property (tx_valid_i |=> tx_fill_o == $past(tx_sel))
    else $error("tx fill flag wrong");
  chk_rx_fill_en: assert property (rx_valid_i |=> rx_fill_o == $past(rx_sel))
    else $error("rx fill flag wrong");
  chk_tx_pass_bit: assert property (tx_valid_i && !tx_sel |=> tx_bit_o == $past(tx_bit_i))
    else $error("tx data altered");
  chk_rx_pass_bit: assert property (rx_valid_i && !rx_sel |=> rx_bit_o == $past(rx_bit_i))
    else $error("rx data altered");
  chk_tx_slot_copy: assert property (tx_valid_i |=> tx_valid_o
    && tx_chan_o == $past(tx_chan_i) && tx_bit_idx_o == $past(tx_bit_idx_i))
    else $error("tx slot not carried");
  chk_rx_slot_copy: assert property (rx_valid_i |=> rx_valid_o
    && rx_chan_o == $past(rx_chan_i) && rx_bit_idx_o == $past(rx_bit_idx_i))
    else $error("rx slot not carried");
  chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not cleared");
  chk_code_readback: assert property (s_ptr_one ##1 s_code_wr ##1 s_code_rd
    |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("entry readback wrong");
  chk_fill_valid: assert property ((tx_fill_o |-> tx_valid_o) and (rx_fill_o |-> rx_valid_o))
    else $error("fill without valid");
endmodule

bind pcic_top pcic_checker #(.NCH(NCH)) i_pcic_checker (.*);

// ---- tb/pcic_frm_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// framer channel stream source, slots 0..32, eight bits each
module pcic_frm_model #(
  parameter INV = 1'b0
) (
  input  wire       core_clk_i,
  input  wire       rst_i,
  input  wire       slow_i,
  output reg        valid_o,
  output reg  [5:0] chan_o,
  output reg  [2:0] idx_o,
  output reg        bit_o
);
  reg [8:0] pos_q;
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      pos_q <= 9'h0;
      valid_o <= 1'b0;
      chan_o <= 6'h0;
      idx_o <= 3'h0;
      bit_o <= 1'b0;
    end else if (slow_i && valid_o && idx_o == 3'h7) begin
      valid_o <= 1'b0;
      bit_o <= ~bit_o;
    end else begin
      valid_o <= 1'b1;
      chan_o <= pos_q[8:3];
      idx_o <= pos_q[2:0];
      bit_o <= pos_q[3] ^ pos_q[0] ^ INV;
      pos_q <= (pos_q == 9'h107) ? 9'h0 : pos_q + 9'h1;
    end
  end
endmodule

// ---- tb/test_per_channel_idle_code_insert.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
// ==========================================================
// bench top
module test_per_channel_idle_code_insert;
  logic       clk = 0, rst = 1, wr = 0, rd = 0, slow = 0, dir = 0;
  logic [7:0] addr = 0, wd = 0, rdat, ptr = 0;
  logic       txv, rxv, txb, rxb, txvo, rxvo, txbo, rxbo, txf, rxf;
  logic [5:0] txc, rxc, txco, rxco;
  logic [2:0] txi, rxi, txio, rxio;
  logic [7:0] tc[0:32], rc[0:32];
  logic [32:0] te = 0, re = 0;
  int         num_errors = 0, n_checks = 0;
  always #50 clk = ~clk;
  pcic_frm_model #(.INV(1'b0)) i_pcic_frm_model_tx (.core_clk_i(clk), .rst_i(rst), .slow_i(slow),
    .valid_o(txv), .chan_o(txc), .idx_o(txi), .bit_o(txb));
  pcic_frm_model #(.INV(1'b1)) i_pcic_frm_model_rx (.core_clk_i(clk), .rst_i(rst), .slow_i(slow),
    .valid_o(rxv), .chan_o(rxc), .idx_o(rxi), .bit_o(rxb));
  pcic_top i_pcic_top (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .tx_valid_i(txv), .tx_chan_i(txc),
    .tx_bit_idx_i(txi), .tx_bit_i(txb), .tx_valid_o(txvo), .tx_chan_o(txco),
    .tx_bit_idx_o(txio), .tx_bit_o(txbo), .tx_fill_o(txf), .rx_valid_i(rxv), .rx_chan_i(rxc),
    .rx_bit_idx_i(rxi), .rx_bit_i(rxb), .rx_valid_o(rxvo), .rx_chan_o(rxco),
    .rx_bit_idx_o(rxio), .rx_bit_o(rxbo), .rx_fill_o(rxf));
  task automatic sb(input string nm, input [5:0] ch, input [2:0] ix, input b, f, e,
                    input [7:0] c, input iv);
    `CHK(nm, {e, e ? c[3'd7 - ix] : ch[0] ^ ix[0] ^ iv}, {f, b})
  endtask
  // stream scoreboard against the shadow arrays
  always @(negedge clk) if (!rst) begin
    if (txvo) sb("tx slot", txco, txio, txbo, txf, txco <= 32 && te[txco], tc[txco], 0);
    if (rxvo) sb("rx slot", rxco, rxio, rxbo, rxf, rxco <= 32 && re[rxco], rc[rxco], 1);
  end
  task automatic upd(input [7:0] a, d);
    if (a == 8'h7E) ptr = d;
    else if (a == 8'h90) dir = d[0];
    else if (a[7:3] == 5'h10 && a[2]) re[a[1:0]*8+1 +: 8] = d;
    else if (a[7:3] == 5'h10) te[a[1:0]*8+1 +: 8] = d;
    else if (a == 8'h7F) for (int i = 1; i <= 32; i++) begin
      if (ptr[6] || (ptr[7:6] == 0 && ptr[5:0] == i && !dir)) tc[i] = d;
      if (ptr[7] || (ptr[7:6] == 0 && ptr[5:0] == i && dir)) rc[i] = d;
    end
  endtask
  task automatic w(input [7:0] a, d);
    @(posedge clk);
    wr <= 1; rd <= 0; addr <= a; wd <= d;
    fork #200 upd(a, d); join_none
  endtask
  task automatic r(input [7:0] a, e);
    @(posedge clk);
    rd <= 1; wr <= 0; addr <= a;
    fork #150 `CHK("read data", e, rdat) join_none
  endtask
  task automatic fin(input string nm);
    @(posedge clk);
    wr <= 0; rd <= 0;
    repeat (300) @(posedge clk);
    $display("test %s done", nm);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 12; i++) r(i < 10 ? 8'h7E + i : (i == 10 ? 8'h90 : 8'hA0), 8'h00);
    fin("reset");
  endtask
  task automatic t_global;
    w(8'h7E, 8'hC0); w(8'h7F, 8'hA5);
    for (int i = 0; i < 8; i++) w(8'h80 + i, 8'hFF);
    fin("global both");
    w(8'h7E, 8'h40); w(8'h7F, 8'h3C); fin("global tx");
    w(8'h7E, 8'h80); w(8'h7F, 8'h5A); fin("global rx");
  endtask
  task automatic t_single;
    w(8'h90, 8'h00); w(8'h7E, 8'h01); w(8'h7F, 8'h81); r(8'h7F, 8'h81);
    w(8'h7E, 8'h20); w(8'h7F, 8'h7E); r(8'h7F, 8'h7E);
    w(8'h90, 8'h01); w(8'h7E, 8'h18); w(8'h7F, 8'hC3); r(8'h7F, 8'hC3);
    w(8'h7E, 8'h00); w(8'h7F, 8'h11); r(8'h7F, 8'h11);
    fin("single channel");
  endtask
  task automatic t_enables;
    logic [7:0] p[8] = '{8'h01, 8'h80, 8'hAA, 8'h55, 8'h0F, 8'hF0, 8'h3C, 8'hC3};
    slow <= 1;
    for (int i = 0; i < 8; i++) w(8'h80 + i, p[i]);
    for (int i = 0; i < 8; i++) r(8'h80 + i, p[i]);
    fin("enable map");
    for (int i = 0; i < 8; i++) w(8'h80 + i, 8'h00);
    fin("pass through");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    for (int i = 0; i <= 32; i++) begin tc[i] = 0; rc[i] = 0; end
    repeat (6) @(posedge clk);
    rst <= 0;
    t_reset;
    t_global;
    t_single;
    t_enables;
    conclude;
  end
  initial begin
    #(100 * 4000);
    num_errors++;
    conclude;
  end
endmodule
